/* src/ivs_cfg.svh */
// Offsets, field positions, reset values and vector layout constants
`ifndef IVS_CFG_SVH
`define IVS_CFG_SVH

// Register offsets on the plain register port (byte-wide address)
`define IVS_OFS_FLAG0      8'h00
`define IVS_OFS_FLAG2      8'h02
`define IVS_OFS_ENABLE0    8'h04
`define IVS_OFS_ENABLE2    8'h06
`define IVS_OFS_PRIO0      8'h10
`define IVS_OFS_PRIO10     8'h1A
`define IVS_OFS_CONTROL    8'h20
`define IVS_OFS_STATUS     8'h24
`define IVS_OFS_MASK       8'h25

// Field positions
`define IVS_CTRL_ALT_BIT   8
`define IVS_STAT_INT_BIT   0
`define IVS_STAT_TRAP_BIT  1
`define IVS_STAT_ALT_BIT   2

// Reset values and write masks
`define IVS_RST_WORD       16'h0000
`define IVS_RST_PC         24'h000000
`define IVS_PRIO_WMASK     16'h7777
`define IVS_CTRL_WMASK     16'h0100
`define IVS_STAT_WMASK     16'h0007

// Request population: 41 requests, 21, 34 and 35 not implemented
`define IVS_NUM_REQ        41
`define IVS_NUM_PRIO_REG   11
`define IVS_REQ_IMPL       48'h01F3_FFDF_FFFF
`define IVS_TRAP_IMPL      8'h5F

// Vector table layout
`define IVS_TRAP_OFS       24'h000004
`define IVS_IRQ_OFS        24'h000014
`define IVS_ALT_PAGE_SHIFT 11

`endif

/* src/ivs_pkg.sv */
// Types shared by the vector select block
package ivs_pkg;

   typedef logic [23:0] ivs_addr_t;
   typedef logic [15:0] ivs_word_t;
   typedef logic [7:0]  ivs_reg_addr_t;
   typedef logic [6:0]  ivs_num_t;
   typedef logic [2:0]  ivs_prio_t;

   // Gray coded along idle, fetch, wait, load
   typedef enum logic [1:0] {
      IVS_IDLE  = 2'b00,
      IVS_FETCH = 2'b01,
      IVS_WAIT  = 2'b11,
      IVS_LOAD  = 2'b10
   } ivs_state_t;

endpackage

/* src/ivs_req_slot.sv */
// Qualifier for one interrupt request: flag, enable and priority
`timescale 1ns/1ps
`default_nettype none
module ivs_req_slot #(
   parameter bit IMPL = 1'b1
) (
   input  wire logic         i_flag,
   input  wire logic         i_enable,
   input  wire ivs_pkg::ivs_prio_t i_prio,
   output logic              o_active,
   output ivs_pkg::ivs_prio_t o_prio
);
   import ivs_pkg::*;

   // A zero priority field disables the source
   always_comb begin
      o_active = IMPL & i_flag & i_enable & (i_prio != 3'h0);
      o_prio   = IMPL ? i_prio : 3'h0;
   end

endmodule
`default_nettype wire

/* src/ivs_vec_addr.sv */
// Vector table base select and entry address former
`timescale 1ns/1ps
`default_nettype none
`include "ivs_cfg.svh"
module ivs_vec_addr (
   input  wire logic         i_alt_on,
   input  wire logic [12:0]  i_boot_segment_limit,
   input  wire logic         i_is_trap,
   input  wire ivs_pkg::ivs_num_t i_num,
   output ivs_pkg::ivs_addr_t o_alt_table_base,
   output ivs_pkg::ivs_addr_t o_addr
);
   import ivs_pkg::*;

   logic [12:0] page;
   ivs_addr_t   offset;
   ivs_addr_t   base;

   always_comb begin
      // Start of the last boot page: (~limit - 1) pages of 0x800
      page             = 13'(~i_boot_segment_limit - 13'h0001);
      o_alt_table_base = {page, 11'h000};
      base             = i_alt_on ? o_alt_table_base : 24'h000000;
      // Same entry layout in both tables, only the base moves
      offset = (i_is_trap ? `IVS_TRAP_OFS : `IVS_IRQ_OFS)
               + {16'h0000, i_num, 1'b0};
      o_addr = base + offset;
   end

endmodule
`default_nettype wire

/* src/ivs_top.sv */
// Interrupt vector select: request registers, arbitration and vector fetch
`timescale 1ns/1ps
`default_nettype none
`include "ivs_cfg.svh"
module ivs_top (
   input  wire logic                  i_clk,
   input  wire logic                  i_nrst,
   input  wire ivs_pkg::ivs_reg_addr_t i_reg_addr,
   input  wire ivs_pkg::ivs_word_t    i_reg_wdata,
   input  wire logic                  i_reg_wr,
   input  wire logic                  i_reg_rd,
   output ivs_pkg::ivs_word_t         o_reg_rdata,
   input  wire logic [40:0]           i_req_event,
   input  wire logic [7:0]            i_trap_event,
   input  wire logic                  i_alt_table_config_permit,
   input  wire logic                  i_boot_region_defined,
   input  wire logic [12:0]           i_boot_segment_limit,
   output logic                       o_fetch_req,
   output ivs_pkg::ivs_addr_t         o_fetch_addr,
   input  wire logic                  i_fetch_valid,
   input  wire ivs_pkg::ivs_addr_t    i_fetch_data,
   output logic                       o_pc_load,
   output ivs_pkg::ivs_addr_t         o_pc_value,
   output logic                       o_taken_is_trap,
   output ivs_pkg::ivs_num_t          o_taken_num,
   output logic                       o_alt_active,
   output logic                       o_irq
);
   import ivs_pkg::*;

   // Register state
   logic [47:0] flag_ff;
   logic [47:0] nxt_flag;
   logic [47:0] enable_ff;
   ivs_word_t   prio_ff [`IVS_NUM_PRIO_REG];
   ivs_word_t   control_ff;
   logic [2:0]  status_ff;
   logic [2:0]  nxt_status;
   logic [2:0]  mask_ff;
   ivs_word_t   rdata_ff;
   ivs_word_t   rd_value;
   logic [7:0]  trap_pend_ff;
   logic [7:0]  nxt_trap_pend;
   // Vectoring state
   ivs_state_t  state_ff;
   ivs_state_t  nxt_state;
   ivs_addr_t   fetch_addr_ff;
   ivs_addr_t   pc_value_ff;
   logic        boot_load_ff;
   logic        taken_trap_ff;
   ivs_num_t    taken_num_ff;
   // Arbitration
   logic        slot_active [`IVS_NUM_REQ];
   ivs_prio_t   slot_prio   [`IVS_NUM_REQ];
   logic        irq_any;
   ivs_num_t    irq_num;
   ivs_prio_t   irq_prio;
   logic        trap_any;
   ivs_num_t    trap_num;
   logic        win_any;
   logic        win_trap;
   ivs_num_t    win_num;
   logic        alt_on;
   ivs_addr_t   win_addr;
   ivs_addr_t   alt_base;
   logic        take_pulse;
   logic [47:0] take_clr;
   logic [7:0]  trap_clr;
   logic        wr_flag;
   logic        wr_enable;
   logic        wr_prio;
   logic        wr_control;
   logic        wr_mask;
   logic [1:0]  wr_word;
   logic [3:0]  prio_idx;
   // Write decode
   always_comb begin
      wr_flag    = 1'b0;
      wr_enable  = 1'b0;
      wr_prio    = 1'b0;
      wr_control = 1'b0;
      wr_mask    = 1'b0;
      wr_word    = 2'(i_reg_addr - `IVS_OFS_FLAG0);
      prio_idx   = 4'(i_reg_addr - `IVS_OFS_PRIO0);
      if (i_reg_addr >= `IVS_OFS_FLAG0 && i_reg_addr <= `IVS_OFS_FLAG2) begin
         wr_flag = i_reg_wr;
      end else if (i_reg_addr >= `IVS_OFS_ENABLE0 && i_reg_addr <= `IVS_OFS_ENABLE2) begin
         wr_enable = i_reg_wr;
         wr_word   = 2'(i_reg_addr - `IVS_OFS_ENABLE0);
      end else if (i_reg_addr >= `IVS_OFS_PRIO0 && i_reg_addr <= `IVS_OFS_PRIO10) begin
         wr_prio = i_reg_wr;
      end else if (i_reg_addr == `IVS_OFS_CONTROL) begin
         wr_control = i_reg_wr;
      end else if (i_reg_addr == `IVS_OFS_MASK) begin
         wr_mask = i_reg_wr;
      end
   end
   // Request flags: an arriving event beats both a software write and a take clear
   always_comb begin
      nxt_flag = flag_ff;
      if (wr_flag) begin
         nxt_flag[16*wr_word +: 16] = i_reg_wdata;
      end
      nxt_flag = (nxt_flag & ~take_clr) | {7'h00, i_req_event};
      nxt_flag = nxt_flag & `IVS_REQ_IMPL;
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         flag_ff <= 48'h0000_0000_0000;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         enable_ff <= 48'h0000_0000_0000;
      end else if (wr_enable) begin
         enable_ff[16*wr_word +: 16] <= i_reg_wdata & 16'(`IVS_REQ_IMPL >> (16*wr_word));
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         for (int k = 0; k < `IVS_NUM_PRIO_REG; k++) begin
            prio_ff[k] <= `IVS_RST_WORD;
         end
      end else if (wr_prio) begin
         prio_ff[prio_idx] <= i_reg_wdata & `IVS_PRIO_WMASK;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         control_ff <= `IVS_RST_WORD;
      end else if (wr_control) begin
         control_ff <= i_reg_wdata & `IVS_CTRL_WMASK;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         mask_ff <= 3'h0;
      end else if (wr_mask) begin
         mask_ff <= i_reg_wdata[2:0];
      end
   end
   // Trap latches; reserved trap slots never become pending
   always_comb begin
      nxt_trap_pend = ((trap_pend_ff & ~trap_clr) | i_trap_event) & `IVS_TRAP_IMPL;
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         trap_pend_ff <= 8'h00;
      end else begin
         trap_pend_ff <= nxt_trap_pend;
      end
   end
   // Per-request qualifiers; request 22 is the one that leaves the n/4 field pattern
   for (genvar n = 0; n < `IVS_NUM_REQ; n++) begin : g_slot
      localparam int PREG = (n == 22) ? 5 : n / 4;
      localparam int PLSB = (n == 22) ? 4 : (n % 4) * 4;
      localparam bit IMPL = 1'(`IVS_REQ_IMPL >> n);
      ivs_req_slot #(
         .IMPL (IMPL)
      ) u_slot (
         .i_flag   (flag_ff[n]),
         .i_enable (enable_ff[n]),
         .i_prio   (prio_ff[PREG][PLSB +: 3]),
         .o_active (slot_active[n]),
         .o_prio   (slot_prio[n])
      );
   end
   // Highest user level wins; strict compare keeps the lower number on a tie
   always_comb begin
      irq_any  = 1'b0;
      irq_num  = 7'h00;
      irq_prio = 3'h0;
      for (int n = 0; n < `IVS_NUM_REQ; n++) begin
         if (slot_active[n] && slot_prio[n] > irq_prio) begin
            irq_any  = 1'b1;
            irq_num  = 7'(n);
            irq_prio = slot_prio[n];
         end
      end
   end
   // Traps are non-maskable and outrank every interrupt, lowest slot first
   always_comb begin
      trap_any = 1'b0;
      trap_num = 7'h00;
      for (int k = 7; k >= 0; k--) begin
         if (trap_pend_ff[k]) begin
            trap_any = 1'b1;
            trap_num = 7'(k);
         end
      end
   end

   always_comb begin
      win_any  = trap_any | irq_any;
      win_trap = trap_any;
      win_num  = trap_any ? trap_num : irq_num;
      alt_on   = control_ff[`IVS_CTRL_ALT_BIT] & i_alt_table_config_permit
                 & i_boot_region_defined;
   end

   ivs_vec_addr u_vec_addr (
      .i_alt_on             (alt_on),
      .i_boot_segment_limit (i_boot_segment_limit),
      .i_is_trap            (win_trap),
      .i_num                (win_num),
      .o_alt_table_base     (alt_base),
      .o_addr               (win_addr)
   );
   // Vectoring sequence: select, fetch entry, wait for handler address, load
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         IVS_IDLE: begin
            if (win_any && !boot_load_ff) begin
               nxt_state = IVS_FETCH;
            end
         end
         IVS_FETCH: begin
            nxt_state = IVS_WAIT;
         end
         IVS_WAIT: begin
            if (i_fetch_valid) begin
               nxt_state = IVS_LOAD;
            end
         end
         IVS_LOAD: begin
            nxt_state = IVS_IDLE;
         end
         default: begin
            nxt_state = IVS_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         state_ff <= IVS_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end
   // Fetch address and the source are frozen at the selection cycle
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         fetch_addr_ff <= `IVS_RST_PC;
         taken_trap_ff <= 1'b0;
         taken_num_ff  <= 7'h00;
      end else if (state_ff == IVS_IDLE && nxt_state == IVS_FETCH) begin
         fetch_addr_ff <= win_addr;
         taken_trap_ff <= win_trap;
         taken_num_ff  <= win_num;
      end
   end
   // Reset loads zero directly, without any table lookup
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         pc_value_ff  <= `IVS_RST_PC;
         boot_load_ff <= 1'b1;
      end else begin
         boot_load_ff <= 1'b0;
         if (state_ff == IVS_WAIT && i_fetch_valid) begin
            pc_value_ff <= i_fetch_data;
         end
      end
   end
   // Taking a source retires its flag or trap latch
   always_comb begin
      take_pulse = (state_ff == IVS_LOAD);
      take_clr   = 48'h0000_0000_0000;
      trap_clr   = 8'h00;
      if (take_pulse && taken_trap_ff) begin
         trap_clr[taken_num_ff[2:0]] = 1'b1;
      end else if (take_pulse) begin
         take_clr[taken_num_ff[5:0]] = 1'b1;
      end
   end
   // Sticky status: set beats the read that clears it
   always_comb begin
      nxt_status = status_ff;
      if (i_reg_rd && i_reg_addr == `IVS_OFS_STATUS) begin
         nxt_status = 3'h0;
      end
      nxt_status[`IVS_STAT_INT_BIT]  = nxt_status[`IVS_STAT_INT_BIT]
                                       | (take_pulse & ~taken_trap_ff);
      nxt_status[`IVS_STAT_TRAP_BIT] = nxt_status[`IVS_STAT_TRAP_BIT]
                                       | (take_pulse & taken_trap_ff);
      nxt_status[`IVS_STAT_ALT_BIT]  = nxt_status[`IVS_STAT_ALT_BIT]
                                       | (take_pulse & alt_on);
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         status_ff <= 3'h0;
      end else begin
         status_ff <= nxt_status;
      end
   end
   // Read mux; unmapped offsets read zero
   always_comb begin
      rd_value = `IVS_RST_WORD;
      if (i_reg_addr >= `IVS_OFS_FLAG0 && i_reg_addr <= `IVS_OFS_FLAG2) begin
         rd_value = flag_ff[16*wr_word +: 16];
      end else if (i_reg_addr >= `IVS_OFS_ENABLE0 && i_reg_addr <= `IVS_OFS_ENABLE2) begin
         rd_value = enable_ff[16*wr_word +: 16];
      end else if (i_reg_addr >= `IVS_OFS_PRIO0 && i_reg_addr <= `IVS_OFS_PRIO10) begin
         rd_value = prio_ff[prio_idx];
      end else if (i_reg_addr == `IVS_OFS_CONTROL) begin
         rd_value = control_ff;
      end else if (i_reg_addr == `IVS_OFS_STATUS) begin
         rd_value = {13'h0000, status_ff};
      end else if (i_reg_addr == `IVS_OFS_MASK) begin
         rd_value = {13'h0000, mask_ff};
      end
   end
   // Read data stands only in the cycle after the strobe
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         rdata_ff <= `IVS_RST_WORD;
      end else begin
         rdata_ff <= i_reg_rd ? rd_value : `IVS_RST_WORD;
      end
   end

   always_comb begin
      o_reg_rdata     = rdata_ff;
      o_fetch_req     = (state_ff == IVS_FETCH);
      o_fetch_addr    = fetch_addr_ff;
      o_pc_load       = boot_load_ff | take_pulse;
      o_pc_value      = pc_value_ff;
      o_taken_is_trap = taken_trap_ff;
      o_taken_num     = taken_num_ff;
      o_alt_active    = alt_on;
      o_irq           = |(status_ff & mask_ff);
   end

endmodule
`default_nettype wire

/* verification/ivs_core_model.sv */
// Processor core stand-in: answers vector fetches with a handler address
`timescale 1ns/1ps
`default_nettype none
module ivs_core_model (
   input  wire logic               i_clk,
   input  wire logic               i_nrst,
   input  wire logic               i_slow,
   input  wire logic               i_fetch_req,
   input  wire ivs_pkg::ivs_addr_t i_fetch_addr,
   output logic                    o_fetch_valid,
   output ivs_pkg::ivs_addr_t      o_fetch_data
);
   import ivs_pkg::*;
   initial begin
      o_fetch_valid = 1'b0;
      o_fetch_data = 24'hFFFFFF;
      forever begin
         @(posedge i_clk);
         if (i_fetch_req === 1'b1 && i_nrst === 1'b1) begin
            repeat (i_slow ? 4 : 0) @(posedge i_clk);
            // Handler is the inverted entry address, so a wrong entry shows in the PC
            o_fetch_valid <= 1'b1;
            o_fetch_data <= ~i_fetch_addr;
            @(posedge i_clk);
            // Released bus shows the inverse of the last value, not a stale copy
            o_fetch_valid <= 1'b0;
            o_fetch_data <= i_fetch_addr;
         end
      end
   end
endmodule
`default_nettype wire

/* verification/ivs_top_properties.sv */
// Port-level checker for the vector select block
`timescale 1ns/1ps
`default_nettype none
module ivs_top_checker (
   input wire logic                   i_clk,
   input wire logic                   i_nrst,
   input wire ivs_pkg::ivs_reg_addr_t i_reg_addr,
   input wire ivs_pkg::ivs_word_t     i_reg_wdata,
   input wire logic                   i_reg_wr,
   input wire logic                   i_reg_rd,
   input wire ivs_pkg::ivs_word_t     o_reg_rdata,
   input wire logic [40:0]            i_req_event,
   input wire logic [7:0]             i_trap_event,
   input wire logic                   i_alt_table_config_permit,
   input wire logic                   i_boot_region_defined,
   input wire logic [12:0]            i_boot_segment_limit,
   input wire logic                   o_fetch_req,
   input wire ivs_pkg::ivs_addr_t     o_fetch_addr,
   input wire logic                   i_fetch_valid,
   input wire ivs_pkg::ivs_addr_t     i_fetch_data,
   input wire logic                   o_pc_load,
   input wire ivs_pkg::ivs_addr_t     o_pc_value,
   input wire logic                   o_taken_is_trap,
   input wire ivs_pkg::ivs_num_t      o_taken_num,
   input wire logic                   o_alt_active,
   input wire logic                   o_irq
);
   import ivs_pkg::*;
   logic [12:0] page;
   ivs_addr_t   exp_addr;
   assign page = ~i_boot_segment_limit - 13'h0001;
   assign exp_addr = (o_alt_active ? {page, 11'h000} : 24'h000000)
                   + (o_taken_is_trap ? 24'h000004 : 24'h000014) + {16'h0000, o_taken_num, 1'b0};
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   sequence s_boot_entry;
      o_pc_load && o_pc_value == 24'h000000;
   endsequence
   sequence s_no_fetch3;
      !o_fetch_req [*3];
   endsequence
   property p_boot_entry;
      $rose(i_nrst) |-> s_boot_entry ##2 !o_pc_load;
   endproperty
   property p_boot_quiet;
      $rose(i_nrst) |-> s_no_fetch3;
   endproperty
   property p_reset_regs;
      $rose(i_nrst) |-> o_reg_rdata == 16'h0000 && !o_irq;
   endproperty
   property p_vec_addr;
      o_fetch_req |-> o_fetch_addr == exp_addr;
   endproperty
   property p_pc_load;
      i_fetch_valid |=> o_pc_load && o_pc_value == $past(i_fetch_data);
   endproperty
   property p_fetch_spacing;
      o_fetch_req |=> s_no_fetch3;
   endproperty
   property p_taken_hold;
      o_fetch_req |=> $stable(o_taken_num) [*2];
   endproperty
   property p_no_alt;
      !(i_alt_table_config_permit && i_boot_region_defined) |-> !o_alt_active;
   endproperty
   property p_rsvd_trap;
      o_fetch_req && o_taken_is_trap |-> o_taken_num != 7'h05 && o_taken_num != 7'h07;
   endproperty
   property p_irq_cause;
      $rose(o_irq) |-> $past(o_pc_load) || $past(i_reg_wr);
   endproperty
   a_boot_entry: assert property (p_boot_entry)
      else $error("reset entry is not a PC load of zero");
   a_boot_quiet: assert property (p_boot_quiet)
      else $error("vector fetch right after reset");
   a_reset_regs: assert property (p_reset_regs)
      else $error("state not cleared by reset");
   a_vec_addr: assert property (p_vec_addr)
      else $error("vector fetch address wrong");
   a_pc_load: assert property (p_pc_load)
      else $error("handler address not loaded into PC");
   a_fetch_spacing: assert property (p_fetch_spacing)
      else $error("fetch request not a single pulse per entry");
   a_taken_hold: assert property (p_taken_hold)
      else $error("taken source changed during fetch");
   a_no_alt: assert property (p_no_alt)
      else $error("alternate table used without permission");
   a_rsvd_trap: assert property (p_rsvd_trap)
      else $error("reserved trap slot vectored");
   a_irq_cause: assert property (p_irq_cause)
      else $error("interrupt output rose without cause");
endmodule
bind ivs_top ivs_top_checker u_checker (
   .i_clk(i_clk), .i_nrst(i_nrst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
   .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
   .i_req_event(i_req_event), .i_trap_event(i_trap_event),
   .i_alt_table_config_permit(i_alt_table_config_permit),
   .i_boot_region_defined(i_boot_region_defined), .i_boot_segment_limit(i_boot_segment_limit),
   .o_fetch_req(o_fetch_req), .o_fetch_addr(o_fetch_addr), .i_fetch_valid(i_fetch_valid),
   .i_fetch_data(i_fetch_data), .o_pc_load(o_pc_load), .o_pc_value(o_pc_value),
   .o_taken_is_trap(o_taken_is_trap), .o_taken_num(o_taken_num),
   .o_alt_active(o_alt_active), .o_irq(o_irq));
`default_nettype wire

/* verification/interrupt_vector_select_bench.sv */
// Self-checking bench for the vector select block
`timescale 1ns/1ps
`default_nettype none
module interrupt_vector_select_bench;
   import ivs_pkg::*;
   localparam int          ROW_N [7] = '{0, 15, 23, 40, 22, 20, 36};
   localparam int          ROW_P [7] = '{1, 7, 3, 2, 5, 4, 6};
   localparam logic [23:0] ROW_A [7] = '{24'h000014, 24'h000032, 24'h000042, 24'h000064,
                                         24'h000040, 24'h00003C, 24'h00005C};
   localparam ivs_reg_addr_t OFS [6] = '{8'h00, 8'h04, 8'h10, 8'h20, 8'h24, 8'h25};
   logic          clk, nrst, wr_s, rd_s, permit, defined, slow, fetch_req, fetch_valid;
   logic          pc_load, taken_trap, alt_active, irq;
   logic [40:0]   req;
   logic [7:0]    trap;
   logic [12:0]   lim;
   ivs_reg_addr_t reg_addr;
   ivs_word_t     wdata, rdata;
   ivs_addr_t     fetch_addr, fetch_data, pc_value;
   ivs_num_t      taken_num;
   int            n_errors = 0;
   int            tests_run = 0;
   int            n_fetch = 0;
   ivs_top DUT (.i_clk(clk), .i_nrst(nrst), .i_reg_addr(reg_addr), .i_reg_wdata(wdata),
      .i_reg_wr(wr_s), .i_reg_rd(rd_s), .o_reg_rdata(rdata), .i_req_event(req),
      .i_trap_event(trap), .i_alt_table_config_permit(permit), .i_boot_region_defined(defined),
      .i_boot_segment_limit(lim), .o_fetch_req(fetch_req), .o_fetch_addr(fetch_addr),
      .i_fetch_valid(fetch_valid), .i_fetch_data(fetch_data), .o_pc_load(pc_load),
      .o_pc_value(pc_value), .o_taken_is_trap(taken_trap), .o_taken_num(taken_num),
      .o_alt_active(alt_active), .o_irq(irq));
   ivs_core_model core (.i_clk(clk), .i_nrst(nrst), .i_slow(slow), .i_fetch_req(fetch_req),
      .i_fetch_addr(fetch_addr), .o_fetch_valid(fetch_valid), .o_fetch_data(fetch_data));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) if (fetch_req === 1'b1) n_fetch <= n_fetch + 1;
   task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input ivs_reg_addr_t a, input ivs_word_t d);
      @(posedge clk); reg_addr <= a; wdata <= d; wr_s <= 1'b1;
      @(posedge clk); wr_s <= 1'b0;
   endtask
   task automatic rd(input ivs_reg_addr_t a, input ivs_word_t e, input string what);
      @(posedge clk); reg_addr <= a; rd_s <= 1'b1;
      @(posedge clk); rd_s <= 1'b0;
      #1 chk(what, {8'h00, rdata}, {8'h00, e});
   endtask
   // Writes whole registers, so sources armed together must not share one
   task automatic arm(input int n, input int p);
      wr(8'h04 + 8'(n / 16), 16'(1 << (n % 16)));
      wr(8'h10 + 8'(n / 4), 16'(p << (4 * ((n == 22) ? 1 : n % 4))));
   endtask
   task automatic pulse(input logic [40:0] r, input logic [7:0] t);
      @(posedge clk); req <= r; trap <= t;
      @(posedge clk); req <= '0; trap <= '0;
   endtask
   task automatic vec(input logic t, input int n, input logic [23:0] a);
      int k;
      k = 0;
      #1;
      while (pc_load !== 1'b1 && k < 40) begin
         @(posedge clk); #1; k++;
      end
      chk("load", {23'h0, pc_load}, 24'h000001);
      chk("trap", {23'h0, taken_trap}, {23'h0, t});
      chk("num", {17'h0, taken_num}, 24'(n));
      chk("addr", fetch_addr, a);
      chk("pc", pc_value, ~a);
      @(posedge clk);
   endtask
   task automatic quiet(input string what);
      int f;
      f = n_fetch;
      repeat (20) @(posedge clk);
      chk(what, 24'(n_fetch), 24'(f));
   endtask
   task automatic do_reset(input int n);
      @(posedge clk); nrst <= 1'b0;
      repeat (n) @(posedge clk);
      #1 chk("boot load", {23'h0, pc_load}, 24'h000001);
      chk("boot pc", pc_value, 24'h000000);
      @(posedge clk); nrst <= 1'b1;
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      #(25 * 20000);
      n_errors++;
      give_verdict();
   end
   initial begin
      nrst = 1'b0; wr_s = 1'b0; rd_s = 1'b0; reg_addr = '0; wdata = '0; req = '0; trap = '0;
      permit = 1'b0; defined = 1'b0; lim = '0; slow = 1'b0;
      do_reset(12);
      for (int k = 0; k < 6; k++) rd(OFS[k], 16'h0000, "reset value");
      $display("test reset done");
      for (int k = 0; k < 7; k++) begin
         slow <= k[0];
         arm(ROW_N[k], ROW_P[k]);
         pulse(41'(1) << ROW_N[k], 8'h00);
         vec(1'b0, ROW_N[k], ROW_A[k]);
      end
      rd(8'h24, 16'h0001, "status");
      $display("test rows done");
      arm(3, 4); arm(17, 4); arm(36, 6);
      pulse((41'(1) << 3) | (41'(1) << 17) | (41'(1) << 36), 8'h00);
      vec(1'b0, 36, 24'h00005C);
      vec(1'b0, 3, 24'h00001A);
      vec(1'b0, 17, 24'h000036);
      $display("test order done");
      arm(2, 0);
      pulse((41'(1) << 2) | (41'(1) << 21) | (41'(1) << 34) | (41'(1) << 35), 8'h00);
      quiet("zero priority");
      rd(8'h00, 16'h0004, "flag0");
      rd(8'h01, 16'h0000, "flag1");
      rd(8'h02, 16'h0000, "flag2");
      wr(8'h00, 16'h0000);
      wr(8'h30, 16'hFFFF);
      rd(8'h30, 16'h0000, "unmapped");
      $display("test refuse done");
      @(posedge clk); permit <= 1'b1; defined <= 1'b1; lim <= 13'h1FF0; slow <= 1'b1;
      wr(8'h20, 16'h0100); wr(8'h25, 16'h0007);
      rd(8'h20, 16'h0100, "control");
      chk("alt", {23'h0, alt_active}, 24'h000001);
      pulse(41'h0, 8'h03);
      vec(1'b1, 0, 24'h007004);
      vec(1'b1, 1, 24'h007006);
      #1 chk("irq", {23'h0, irq}, 24'h000001);
      rd(8'h24, 16'h0007, "status alt");
      chk("irq clear", {23'h0, irq}, 24'h000000);
      arm(40, 2);
      pulse(41'(1) << 40, 8'h00);
      vec(1'b0, 40, 24'h007064);
      pulse(41'h0, 8'hA0);
      quiet("reserved traps");
      @(posedge clk); permit <= 1'b0; slow <= 1'b0;
      arm(0, 1);
      pulse(41'h1, 8'h00);
      vec(1'b0, 0, 24'h000014);
      $display("test alt done");
      // Reset lands in mid-fetch; the pending flag must be gone afterwards
      arm(12, 3);
      pulse(41'(1) << 12, 8'h00);
      do_reset(2);
      quiet("after reset");
      rd(8'h04, 16'h0000, "enable after reset");
      $display("test mid reset done");
      give_verdict();
   end
endmodule
`default_nettype wire
